/* logic/dpctl_pkg.sv */
// How it works
// - write strobe stays high whenever this controller changes address lines.
// - with output enable low, pulse spans turn-off delay plus data setup.
// - memory access drives port select low and flag-latch select high.
// - controller never drives data pins while the device may drive them.
// - a flag write drives the requested value on data bit zero, other bits high, with memory select high.
// - flag write then read keeps memory select high through both cycles.
// - flag update pulse at least 10 ns; 5 ns from flag write to read.
// - on a slave, write strobe stays high until hold time after busy rises.
`default_nettype none
package dpctl_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int WRITE_PULSE_NS = 15;
    localparam int TURN_OFF_NS = 12;
    localparam int DATA_SETUP_NS = 15;
    localparam int FLAG_UPDATE_PULSE_NS = 10;
    localparam int FLAG_WRITE_TO_READ_NS = 5;
    localparam int SLAVE_HOLD_AFTER_RELEASE_NS = 15;
    localparam int RELEASE_TO_DATA_VALID_NS = 20;
    localparam int ACCESS_NS = 20;
    // least times round up, never below one cycle
    localparam int WP_NS = (WRITE_PULSE_NS > TURN_OFF_NS + DATA_SETUP_NS) ?
        WRITE_PULSE_NS : TURN_OFF_NS + DATA_SETUP_NS;
    localparam int WRITE_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLAG_PULSE_CYC =
        (FLAG_UPDATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLAG_GAP_CYC =
        (FLAG_WRITE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLAVE_HOLD_CYC =
        (SLAVE_HOLD_AFTER_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC =
        ((ACCESS_NS > RELEASE_TO_DATA_VALID_NS ? ACCESS_NS :
          RELEASE_TO_DATA_VALID_NS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [3:0] CNT_W_ONE = 4'h1;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_FLAG_WRITE = 2'h2;
    localparam logic [1:0] OP_FLAG_READ = 2'h3;
    typedef enum logic [5:0] {
        DPCTL_IDLE   = 6'h01,
        DPCTL_SETUP  = 6'h02,
        DPCTL_WAIT   = 6'h04,
        DPCTL_STROBE = 6'h08,
        DPCTL_GAP    = 6'h10,
        DPCTL_DONE   = 6'h20
    } dpctl_state_t;
endpackage : dpctl_pkg
`default_nettype wire

/* logic/dpctl_sync.sv */
`default_nettype none
// ----------------------------------------
// two-stage synchroniser for pin inputs
// ----------------------------------------
module dpctl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    // first stage feeds only the second stage
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_r <= '1;
            sync_o <= '1;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : dpctl_sync
`default_nettype wire

/* logic/dpctl_port_master.sv */
`default_nettype none
// ----------------------------------------
// controller for one port of the dual-port ram
// ----------------------------------------
module dpctl_port_master #(
    parameter int ADDR_W = dpctl_pkg::ADDR_W,
    parameter int DATA_W = dpctl_pkg::DATA_W,
    parameter bit SLAVE_DEV = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // user request side
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [1:0] req_op_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    input wire logic [1:0] req_lane_i,
    input wire logic [2:0] req_flag_i,
    output logic rsp_valid_o,
    output logic [DATA_W-1:0] rsp_rdata_o,
    input wire logic mbox_ack_i,
    output logic mbox_irq_o,
    // device pins
    output logic [ADDR_W-1:0] addr_o,
    output logic port_select_n_o,
    output logic flag_latch_select_n_o,
    output logic write_n_o,
    output logic output_enable_n_o,
    output logic upper_byte_lane_n_o,
    output logic lower_byte_lane_n_o,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic busy_n_i,
    input wire logic irq_n_i
);
    // the flag encoding and byte lanes serve one 16-bit word only
    if (DATA_W != 16 || ADDR_W < 3 || ADDR_W > 16) begin : g_bad_width
        $error("dpctl_port_master: unsupported width");
    end

    dpctl_pkg::dpctl_state_t state_r;
    logic [1:0] op_r;
    logic [3:0] cnt_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic busy_n_s;
    logic irq_n_s;
    logic [DATA_W-1:0] data_s;
    logic is_write;
    logic is_flag;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    dpctl_sync #(.WIDTH(DATA_W + 2)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({busy_n_i, irq_n_i, data_i}),
        .sync_o({busy_n_s, irq_n_s, data_s})
    );

    assign is_write = (op_r == dpctl_pkg::OP_WRITE) ||
                      (op_r == dpctl_pkg::OP_FLAG_WRITE);
    assign is_flag = op_r[1];
    assign req_ready_o = (state_r == dpctl_pkg::DPCTL_IDLE);
    assign mbox_irq_o = ~irq_n_s;  // owner clears it by reading its mailbox

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // address latches in idle only and selects change in idle and done, so they never move
    // while the write strobe is low
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_r <= dpctl_pkg::DPCTL_IDLE;
            op_r <= dpctl_pkg::OP_READ;
            cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                dpctl_pkg::DPCTL_IDLE: begin
                    if (req_valid_i) begin
                        op_r <= req_op_i;
                        state_r <= dpctl_pkg::DPCTL_SETUP;
                    end
                end
                dpctl_pkg::DPCTL_SETUP: begin
                    // wait for busy to settle before any strobe
                    state_r <= dpctl_pkg::DPCTL_WAIT;
                    cnt_r <= 4'h0;
                end
                dpctl_pkg::DPCTL_WAIT: begin
                    // busy needs both sync flops to reflect the new address,
                    // so the first wait cycle never strobes; a slave also
                    // keeps a write off for the hold time after release
                    if (!busy_n_s && !is_flag) begin
                        cnt_r <= 4'h0;
                    end else if (cnt_r != 4'h0 &&
                                 (!SLAVE_DEV || !is_write || is_flag ||
                                 cnt_r >= 4'(dpctl_pkg::SLAVE_HOLD_CYC))) begin
                        state_r <= dpctl_pkg::DPCTL_STROBE;
                        cnt_r <= 4'h0;
                    end else begin
                        cnt_r <= cnt_r + dpctl_pkg::CNT_W_ONE;
                    end
                end
                dpctl_pkg::DPCTL_STROBE: begin
                    cnt_r <= cnt_r + dpctl_pkg::CNT_W_ONE;
                    // a flag read waits out the read path like a word read
                    if (is_flag && is_write) begin
                        if (cnt_r + dpctl_pkg::CNT_W_ONE >=
                            4'(dpctl_pkg::FLAG_PULSE_CYC)) begin
                            state_r <= dpctl_pkg::DPCTL_GAP;
                            cnt_r <= 4'h0;
                        end
                    end else if (is_write) begin
                        if (cnt_r + dpctl_pkg::CNT_W_ONE >=
                            4'(dpctl_pkg::WRITE_CYC)) begin
                            state_r <= dpctl_pkg::DPCTL_GAP;
                            cnt_r <= 4'h0;
                        end
                    end else if (cnt_r + dpctl_pkg::CNT_W_ONE >=
                                 4'(dpctl_pkg::READ_CYC) + 4'h2) begin
                        state_r <= dpctl_pkg::DPCTL_GAP;
                        cnt_r <= 4'h0;
                    end
                end
                dpctl_pkg::DPCTL_GAP: begin
                    // flag write to read gap, also lets data pins turn round
                    if (cnt_r + dpctl_pkg::CNT_W_ONE >=
                        4'(dpctl_pkg::FLAG_GAP_CYC)) begin
                        state_r <= dpctl_pkg::DPCTL_DONE;
                    end else begin
                        cnt_r <= cnt_r + dpctl_pkg::CNT_W_ONE;
                    end
                end
                dpctl_pkg::DPCTL_DONE: begin
                    state_r <= dpctl_pkg::DPCTL_IDLE;
                end
                default: begin
                    state_r <= dpctl_pkg::DPCTL_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            addr_o <= '0;
            port_select_n_o <= 1'b1;
            flag_latch_select_n_o <= 1'b1;
            write_n_o <= 1'b1;
            output_enable_n_o <= 1'b1;
            upper_byte_lane_n_o <= 1'b1;
            lower_byte_lane_n_o <= 1'b1;
            data_o <= '0;
            data_oe_o <= 1'b0;
        end else begin
            write_n_o <= 1'b1;
            output_enable_n_o <= 1'b1;
            data_oe_o <= 1'b0;
            if (state_r == dpctl_pkg::DPCTL_IDLE && req_valid_i) begin
                if (req_op_i[1]) begin
                    // flag: memory select high, flag select low
                    addr_o <= ADDR_W'(req_flag_i);
                    port_select_n_o <= 1'b1;
                    flag_latch_select_n_o <= 1'b0;
                    upper_byte_lane_n_o <= 1'b1;
                    lower_byte_lane_n_o <= 1'b1;
                    data_o <= {{(DATA_W-1){1'b1}}, req_wdata_i[0]};
                end else begin
                    addr_o <= req_addr_i;
                    port_select_n_o <= 1'b0;
                    flag_latch_select_n_o <= 1'b1;
                    upper_byte_lane_n_o <= ~req_lane_i[1];
                    lower_byte_lane_n_o <= ~req_lane_i[0];
                    data_o <= req_wdata_i;
                end
            end else if (state_r == dpctl_pkg::DPCTL_DONE) begin
                port_select_n_o <= 1'b1;
                flag_latch_select_n_o <= 1'b1;
                upper_byte_lane_n_o <= 1'b1;
                lower_byte_lane_n_o <= 1'b1;
            end
            if (state_r == dpctl_pkg::DPCTL_STROBE) begin
                // drive data only with output enable high, never both
                write_n_o <= ~is_write;
                output_enable_n_o <= is_write;
                data_oe_o <= is_write;
                // strobe and data follow the strobe cycles one edge late and lift together
                // on the edge that ends the first gap cycle, so the pulse is the full count
            end
        end
    end

    // ----------------------------------------
    // read capture and answer
    // ----------------------------------------
    always_comb begin
        rdata_nxt = data_s;
        if (is_flag) rdata_nxt = {{(DATA_W-1){1'b0}}, data_s[0]};
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end else begin
            rsp_valid_o <= (state_r == dpctl_pkg::DPCTL_DONE);
            if (state_r == dpctl_pkg::DPCTL_GAP && !is_write)
                rsp_rdata_o <= rdata_nxt;
        end
    end

    logic unused_ack;
    assign unused_ack = mbox_ack_i;
endmodule : dpctl_port_master
`default_nettype wire

/* test/dpctl_chk.sv */
`default_nettype none
// --------------------------------
// pin checker for the port master
// --------------------------------
module dpctl_chk #(
    parameter int ADDR_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic mbox_irq_o,
    input wire logic [ADDR_W-1:0] addr_o,
    input wire logic port_select_n_o,
    input wire logic flag_latch_select_n_o,
    input wire logic write_n_o,
    input wire logic output_enable_n_o,
    input wire logic upper_byte_lane_n_o,
    input wire logic lower_byte_lane_n_o,
    input wire logic data_oe_o,
    input wire logic busy_n_i,
    input wire logic irq_n_i
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // pin relations; busy and irq allow for the two-flop sync delay
    AST_ADDR_HOLD: assert property (!write_n_o |-> $stable(addr_o))
        else $error("address moved under the strobe");
    AST_MEM_SEL: assert property (
        !port_select_n_o |-> flag_latch_select_n_o)
        else $error("both selects low");
    AST_FLAG_SEL: assert property (
        !flag_latch_select_n_o |-> port_select_n_o)
        else $error("memory select low in flag access");
    AST_NO_FIGHT: assert property (data_oe_o |-> output_enable_n_o)
        else $error("data driven while device may drive");
    AST_LANE_WRITE: assert property (
        !write_n_o && !port_select_n_o |->
        !(upper_byte_lane_n_o && lower_byte_lane_n_o))
        else $error("memory write without a lane");
    AST_SEL_FIRST: assert property ($fell(write_n_o) |->
        !$past(port_select_n_o) || !$past(flag_latch_select_n_o))
        else $error("select not low before strobe");
    AST_WRITE_DATA: assert property (!write_n_o |-> data_oe_o)
        else $error("write strobe without data");
    AST_BUSY_BLOCK: assert property (
        (!busy_n_i && write_n_o) [*3] |=> write_n_o || port_select_n_o)
        else $error("memory write started while busy");
    AST_SLAVE_HOLD: assert property (
        !busy_n_i [*3] ##1 (busy_n_i && write_n_o) |=> write_n_o)
        else $error("write too soon after busy release");
    AST_IRQ_FOLLOW: assert property (!irq_n_i [*4] |-> mbox_irq_o)
        else $error("mailbox interrupt not shown");
    COV_MEM_WRITE: cover property (!write_n_o && !port_select_n_o);
    COV_FLAG_WRITE: cover property (!write_n_o && !flag_latch_select_n_o);
    COV_BLOCKED: cover property ((!busy_n_i && !port_select_n_o) [*5]);
endmodule : dpctl_chk
`default_nettype wire

/* test/dpctl_dev_model.sv */
`default_nettype none
// --------------------------------
// behavioural model of one device port
// --------------------------------
module dpctl_dev_model (
    input wire logic sys_clk_i,
    input wire logic [15:0] addr_i,
    input wire logic port_select_n_i,
    input wire logic flag_latch_select_n_i,
    input wire logic write_n_i,
    input wire logic output_enable_n_i,
    input wire logic upper_byte_lane_n_i,
    input wire logic lower_byte_lane_n_i,
    input wire logic [15:0] ctl_data_i,
    input wire logic ctl_data_oe_i,
    input wire logic contend_i,
    input wire logic [15:0] contend_addr_i,
    input wire logic mbox_set_i,
    output logic [15:0] bus_o,
    output logic busy_n_o,
    output logic irq_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [logic [15:0]];
    logic [7:0] flags = 8'hff;
    logic [15:0] junk = 16'h0f0f;
    logic [15:0] word, rd_word;
    logic irq_n_r = 1'b1;
    wire wr_act = !write_n_i && (!port_select_n_i || !flag_latch_select_n_i);
    wire drive = write_n_i && !output_enable_n_i;
    wire mrd = drive && !port_select_n_i;
    wire own_read = mrd && addr_i == 16'h7ffe;
    assign irq_n_o = irq_n_r;
    // busy is an output here: other port holds the same word
    assign busy_n_o = !(contend_i && !port_select_n_i &&
        addr_i == contend_addr_i);
    // released lines move every cycle so stale data cannot pass
    always @(posedge sys_clk_i) junk <= junk + 16'h3b5d;
    // write lands at the end of the overlap, never while busy
    always @(negedge wr_act) begin
        if (!port_select_n_i && busy_n_o) begin
            word = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
            if (!upper_byte_lane_n_i) word[15:8] = ctl_data_i[15:8];
            if (!lower_byte_lane_n_i) word[7:0] = ctl_data_i[7:0];
            mem[addr_i] = word;
        end else if (!flag_latch_select_n_i) begin
            flags[addr_i[2:0]] = ctl_data_i[0];
        end
    end
    // only enabled lanes carry read data; a flag read gives bit zero
    always @* begin
        bus_o = ctl_data_oe_i ? ctl_data_i : junk;
        rd_word = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
        if (drive && !flag_latch_select_n_i) bus_o[0] = flags[addr_i[2:0]];
        if (mrd && !upper_byte_lane_n_i) bus_o[15:8] = rd_word[15:8];
        if (mrd && !lower_byte_lane_n_i) bus_o[7:0] = rd_word[7:0];
    end
    // other port writing our mailbox sets, our own read clears
    always @(posedge mbox_set_i or posedge own_read)
        irq_n_r = !mbox_set_i;
endmodule : dpctl_dev_model
`default_nettype wire

/* test/testbench.sv */
`default_nettype none
// --------------------------------
// bench for one controlled port
// --------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, rst_n_i = 0, req_valid_i = 0, mbox_ack_i = 0;
    logic contend = 0, mbox_set = 0;
    logic [1:0] req_op_i = 0, req_lane_i = 0;
    logic [2:0] req_flag_i = 0;
    logic [15:0] req_addr_i = 0, req_wdata_i = 0;
    logic req_ready_o, rsp_valid_o, mbox_irq_o, port_select_n_o, write_n_o;
    logic flag_latch_select_n_o, output_enable_n_o, data_oe_o, busy_n_i;
    logic upper_byte_lane_n_o, lower_byte_lane_n_o, irq_n_i;
    logic [15:0] rsp_rdata_o, addr_o, data_i, data_o;
    int mismatches = 0;
    int comparisons = 0;
    dpctl_port_master #(.SLAVE_DEV(1'b1)) u_dpctl_port_master (
        .sys_clk_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_op_i,
        .req_addr_i, .req_wdata_i, .req_lane_i, .req_flag_i, .rsp_valid_o,
        .rsp_rdata_o, .mbox_ack_i, .mbox_irq_o, .addr_o, .port_select_n_o,
        .flag_latch_select_n_o, .write_n_o, .output_enable_n_o,
        .upper_byte_lane_n_o, .lower_byte_lane_n_o, .data_i, .data_o,
        .data_oe_o, .busy_n_i, .irq_n_i);
    dpctl_dev_model u_dpctl_dev_model (
        .sys_clk_i, .addr_i(addr_o), .port_select_n_i(port_select_n_o),
        .flag_latch_select_n_i(flag_latch_select_n_o),
        .write_n_i(write_n_o), .output_enable_n_i(output_enable_n_o),
        .upper_byte_lane_n_i(upper_byte_lane_n_o),
        .lower_byte_lane_n_i(lower_byte_lane_n_o), .ctl_data_i(data_o),
        .ctl_data_oe_i(data_oe_o), .contend_i(contend),
        .contend_addr_i(16'h0020), .mbox_set_i(mbox_set), .bus_o(data_i),
        .busy_n_o(busy_n_i), .irq_n_o(irq_n_i));
    task automatic chk(input string nm, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one request, held until taken; cyc counts every edge it costs
    task automatic do_op(input logic [1:0] op, input logic [15:0] a, d,
            input logic [1:0] ln, output int cyc);
        cyc = 0;
        req_op_i <= op;
        req_addr_i <= a;
        req_wdata_i <= d;
        req_lane_i <= ln;
        req_flag_i <= a[2:0];
        req_valid_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            cyc++;
        end while (req_ready_o !== 1'b1 && cyc < 100);
        req_valid_i <= 1'b0;
        while (rsp_valid_o !== 1'b1 && cyc < 200) begin
            @(posedge sys_clk_i);
            cyc++;
        end
        chk("response", {15'h0, rsp_valid_o}, 16'h1);
    endtask : do_op
    task automatic t_word();
        int c;
        do_op(dpctl_pkg::OP_WRITE, 16'h0010, 16'hbeef, 2'h3, c);
        do_op(dpctl_pkg::OP_WRITE, 16'h0011, 16'ha5a5, 2'h3, c);
        do_op(dpctl_pkg::OP_WRITE, 16'h0010, 16'h1234, 2'h2, c);
        do_op(dpctl_pkg::OP_WRITE, 16'h0011, 16'h0077, 2'h1, c);
        do_op(dpctl_pkg::OP_READ, 16'h0010, 16'h0000, 2'h3, c);
        chk("upper lane word", rsp_rdata_o, 16'h12ef);
        do_op(dpctl_pkg::OP_READ, 16'h0011, 16'h0000, 2'h3, c);
        chk("lower lane word", rsp_rdata_o, 16'ha577);
    endtask : t_word
    task automatic t_flag();
        int c;
        for (int f = 0; f < 8; f += 7) begin
            do_op(dpctl_pkg::OP_FLAG_READ, 16'(f), 16'h0, 2'h0, c);
            chk("flag at start", {15'h0, rsp_rdata_o[0]}, 16'h1);
            for (int v = 0; v < 2; v++) begin
                do_op(dpctl_pkg::OP_FLAG_WRITE, 16'(f), 16'(v), 2'h0, c);
                do_op(dpctl_pkg::OP_FLAG_READ, 16'(f), 16'h0, 2'h0, c);
                chk("flag state", {15'h0, rsp_rdata_o[0]}, 16'(v));
            end
        end
    endtask : t_flag
    task automatic t_mbox();
        int c;
        mbox_set <= 1'b1;
        @(posedge sys_clk_i);
        mbox_set <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        chk("irq raised", {15'h0, mbox_irq_o}, 16'h1);
        do_op(dpctl_pkg::OP_READ, 16'h7fff, 16'h0, 2'h3, c);
        chk("irq after other read", {15'h0, mbox_irq_o}, 16'h1);
        do_op(dpctl_pkg::OP_READ, 16'h7ffe, 16'h0, 2'h3, c);
        repeat (4) @(posedge sys_clk_i);
        chk("irq after own read", {15'h0, mbox_irq_o}, 16'h0);
    endtask : t_mbox
    // contention on one word only; a neighbour must not wait
    task automatic t_busy();
        int c;
        contend <= 1'b1;
        do_op(dpctl_pkg::OP_WRITE, 16'h0021, 16'h0bad, 2'h3, c);
        chk("free word delay", {15'h0, c < 20}, 16'h1);
        fork
            begin
                repeat (20) @(posedge sys_clk_i);
                contend <= 1'b0;
            end
            do_op(dpctl_pkg::OP_WRITE, 16'h0020, 16'hc0de, 2'h3, c);
        join
        chk("write held", {15'h0, c > 20}, 16'h1);
        do_op(dpctl_pkg::OP_READ, 16'h0020, 16'h0, 2'h3, c);
        chk("word after busy", rsp_rdata_o, 16'hc0de);
    endtask : t_busy
    task automatic finish_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        t_word();
        t_flag();
        t_mbox();
        t_busy();
        finish_test();
    end
    // hang guard, far past the few hundred cycles the tests take
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        mismatches++;
        finish_test();
    end
endmodule : testbench
bind dpctl_port_master dpctl_chk #(.ADDR_W(ADDR_W)) u_dpctl_chk (
    .sys_clk_i, .rst_n_i, .mbox_irq_o, .addr_o, .port_select_n_o,
    .flag_latch_select_n_o, .write_n_o, .output_enable_n_o,
    .upper_byte_lane_n_o, .lower_byte_lane_n_o, .data_oe_o, .busy_n_i,
    .irq_n_i);
`default_nettype wire
